// file: logic/cwlp_pkg.sv
/*
  Constants, encodings and state type shared by the clock, watchdog and low-power control block.
  Assumes a single 50 MHz system clock domain.
*/
package cwlp_pkg;

  // Clock rate and timing
  localparam int CLK_HZ = 50000000;
  localparam int PLL_SETTLE_REF_CYCLES = 131072;
  localparam int WD_PULSE_OSC_CYCLES = 512;
  localparam int WD_PULSE_W = 10;
  localparam logic [WD_PULSE_W-1:0] WD_PULSE_LAST = 10'(WD_PULSE_OSC_CYCLES - 1);

  // Watchdog
  localparam int WD_CNT_W = 8;
  localparam logic [WD_CNT_W-1:0] WD_CNT_MAX = 8'hff;
  localparam logic [7:0] WD_KEY_FIRST = 8'h55;
  localparam logic [7:0] WD_KEY_SECOND = 8'haa;

  // PLL ratio field
  localparam int RATIO_W = 4;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 4'h0;
  localparam logic [RATIO_W-1:0] RATIO_MAX_LEGAL = 4'ha;

  // Clock path select codes
  localparam logic [1:0] CLKSEL_DIRECT = 2'h0;
  localparam logic [1:0] CLKSEL_BYPASS_DIV2 = 2'h1;
  localparam logic [1:0] CLKSEL_PLL = 2'h2;
  localparam logic [1:0] CLKSEL_LIMP = 2'h3;

  // Low-power select encodings
  localparam logic [1:0] LPM_IDLE = 2'h0;
  localparam logic [1:0] LPM_STANDBY = 2'h1;
  localparam int LPM_HALT_BIT = 1;

  // Wake-select bit positions
  localparam int WAKE_W = 8;
  localparam int WAKE_WD = 0;
  localparam int WAKE_EXTERNAL_INTERRUPT_ONE = 1;
  localparam int WAKE_NMI = 2;
  localparam int WAKE_TTRIP = 3;
  localparam int WAKE_CTRIP = 4;
  localparam int WAKE_SERIAL = 5;
  localparam int WAKE_BUS = 6;
  localparam int WAKE_DEBUG = 7;

  // Qualification count width
  localparam int QUAL_W = 6;

  // Low-power state machine, one-hot
  typedef enum logic [3:0] {
    CWLP_RUN = 4'b0001,
    CWLP_IDLE = 4'b0010,
    CWLP_STANDBY = 4'b0100,
    CWLP_HALT = 4'b1000
  } cwlp_state_t;

endpackage

// file: logic/cwlp_top.sv
/*
  Clock select, limp-mode fallback, 8-bit watchdog with key restart and reset pulse,
  and IDLE / STANDBY / HALT low-power sequencing with qualified wake.
  Assumes all inputs synchronous to mclk; the analog PLL and oscillator are outside and
  are steered by the select and stop outputs. Register writes arrive as strobes with data,
  already gated by the protected-write enable in the core.
*/
`timescale 1ns/1ps
module cwlp_top
  import cwlp_pkg::*;
(
  // Clock and external reset pin
  input wire logic mclk,
  input wire logic rst_n,
  // Debugger reset, leaves the ratio alone
  input wire logic debug_reset,
  // Straps and reference status
  input wire logic pll_disable_strap_n,
  input wire logic reference_lost,
  // Ratio register write
  input wire logic pll_ratio_wr,
  input wire logic [RATIO_W-1:0] pll_ratio_wdata,
  // Watchdog control
  input wire logic wd_enable,
  input wire logic wd_key_wr,
  input wire logic [7:0] wd_key_wdata,
  input wire logic wd_wake_mode,
  input wire logic oscillator_clock_tick,
  // Low-power control
  input wire logic idle_instr,
  input wire logic [1:0] lowpower_select,
  input wire logic [QUAL_W-1:0] lowpower_qual_count,
  input wire logic [WAKE_W-1:0] lowpower_wake_select,
  input wire logic nmi_enable,
  // Wake sources, active low except debugger_wake and enabled_interrupt
  input wire logic nonmaskable_ext_input_n,
  input wire logic external_interrupt_one_n,
  input wire logic timer_trip_inputs_n,
  input wire logic compare_trip_inputs_n,
  input wire logic serial_receive_wake_n,
  input wire logic bus_receive_wake_n,
  input wire logic debugger_wake,
  input wire logic enabled_interrupt,
  // Pins held across low-power modes
  input wire logic [7:0] pin_out_d,
  output logic [7:0] pin_out,
  // Clock control outputs
  output logic [RATIO_W-1:0] pll_ratio_register,
  output logic [1:0] clk_path_sel,
  output logic pll_enable,
  output logic ratio_reserved,
  output logic core_clock_run,
  output logic system_clock_run,
  output logic oscillator_run,
  output logic peripheral_clock_run,
  // Watchdog outputs
  output logic [WD_CNT_W-1:0] wd_count,
  output logic watchdog_reset_out_n,
  output logic watchdog_wake_interrupt,
  output logic cpu_wake_irq,
  // Low-power status
  output logic [3:0] lp_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic [1:0] rst_sync_q;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic strap_taken;
    logic pll_disabled;
    logic [RATIO_W-1:0] ratio;
    logic [1:0] clk_sel;
    logic pll_en;
    logic reserved;
    logic [WD_CNT_W-1:0] wd_cnt;
    logic key_armed;
    logic [WD_PULSE_W-1:0] pulse_cnt;
    logic pulse_on;
    logic wd_rst_n;
    logic wd_int;
    logic cpu_irq;
    cwlp_state_t lp;
    logic [7:0] pins;
    logic core_run;
    logic osc_run;
    logic per_run;
  } cwlp_top_t;

  cwlp_top_t s_q;
  cwlp_top_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Wake sources and qualification

  logic [WAKE_W-1:0] wake_low;
  logic [WAKE_W-1:0] wake_qualified;
  logic in_standby;
  logic wd_wake_low;

  assign in_standby = (s_q.lp == CWLP_STANDBY);
  assign wd_wake_low = ~s_q.wd_int;

  always_comb begin
    wake_low = '1;
    wake_low[WAKE_WD] = wd_wake_low;
    wake_low[WAKE_EXTERNAL_INTERRUPT_ONE] = external_interrupt_one_n;
    wake_low[WAKE_NMI] = nonmaskable_ext_input_n;
    wake_low[WAKE_TTRIP] = timer_trip_inputs_n;
    wake_low[WAKE_CTRIP] = compare_trip_inputs_n;
    wake_low[WAKE_SERIAL] = serial_receive_wake_n;
    wake_low[WAKE_BUS] = bus_receive_wake_n;
    wake_low[WAKE_DEBUG] = ~debugger_wake;
  end

  // One qualifier per wake source; unselected ones stay disarmed
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_W; gi++) begin : g_qual
      cwlp_wake_qual #(
        .W(QUAL_W)
      ) u_qual (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .arm(in_standby && lowpower_wake_select[gi]),
        .qual_count(lowpower_qual_count),
        .wake_low(wake_low[gi]),
        .qualified(wake_qualified[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic key_first;
  logic key_second;
  logic wd_advance;
  logic wd_set;
  logic limp;

  always_comb begin
    s_d = s_q;
    key_first = wd_key_wr && (wd_key_wdata == WD_KEY_FIRST);
    key_second = wd_key_wr && (wd_key_wdata == WD_KEY_SECOND);
    s_d.cpu_irq = 1'b0;
    wd_set = 1'b0;

    // Strap is captured once after reset release
    if (!s_q.strap_taken) begin
      s_d.strap_taken = 1'b1;
      s_d.pll_disabled = ~pll_disable_strap_n;
    end

    // Ratio field; debugger reset does not touch it
    if (pll_ratio_wr) begin
      s_d.ratio = pll_ratio_wdata;
    end
    s_d.reserved = (s_d.ratio > RATIO_MAX_LEGAL);

    // Clock path selection
    limp = 1'b0;
    if (s_d.pll_disabled) begin
      s_d.clk_sel = CLKSEL_DIRECT;
      s_d.pll_en = 1'b0;
    end else if (s_d.ratio == RATIO_RESET) begin
      s_d.clk_sel = CLKSEL_BYPASS_DIV2;
      s_d.pll_en = 1'b0;
    end else if (reference_lost) begin
      s_d.clk_sel = CLKSEL_LIMP;
      s_d.pll_en = 1'b1;
      limp = 1'b1;
    end else begin
      s_d.clk_sel = CLKSEL_PLL;
      s_d.pll_en = 1'b1;
    end

    // Watchdog: no clock in HALT, frozen on limp clock, held while its reset pulse stands
    wd_advance = wd_enable && oscillator_clock_tick && !limp && s_q.osc_run && !s_q.pulse_on;
    if (key_first) begin
      s_d.key_armed = 1'b1;
    end else if (key_second && s_q.key_armed) begin
      s_d.key_armed = 1'b0;
      s_d.wd_cnt = '0;
    end else if (wd_key_wr) begin
      s_d.key_armed = 1'b0;
    end
    if (!(key_second && s_q.key_armed) && wd_advance) begin
      if (s_q.wd_cnt == WD_CNT_MAX) begin
        s_d.wd_cnt = '0;
        if (wd_wake_mode) begin
          s_d.wd_int = 1'b1;
          wd_set = 1'b1;
        end else begin
          s_d.pulse_on = 1'b1;
          s_d.pulse_cnt = '0;
        end
      end else begin
        s_d.wd_cnt = WD_CNT_W'(s_q.wd_cnt + 1'b1);
      end
    end
    if (!wd_enable) begin
      s_d.wd_cnt = '0;
    end

    // Reset pulse width counted in oscillator clocks
    if (s_q.pulse_on && oscillator_clock_tick) begin
      if (s_q.pulse_cnt == WD_PULSE_LAST) begin
        s_d.pulse_on = 1'b0;
      end else begin
        s_d.pulse_cnt = WD_PULSE_W'(s_q.pulse_cnt + 1'b1);
      end
    end
    s_d.wd_rst_n = ~s_d.pulse_on;

    // Low-power sequencing
    case (s_q.lp)
      CWLP_RUN: begin
        s_d.pins = pin_out_d;
        if (idle_instr) begin
          if (lowpower_select[LPM_HALT_BIT]) begin
            s_d.lp = CWLP_HALT;
          end else if (lowpower_select == LPM_STANDBY) begin
            s_d.lp = CWLP_STANDBY;
          end else begin
            s_d.lp = CWLP_IDLE;
          end
        end
      end
      CWLP_IDLE: begin
        if (s_q.wd_int) begin
          s_d.cpu_irq = 1'b1;
        end
        if (s_q.wd_int || enabled_interrupt || debugger_wake ||
            (!nonmaskable_ext_input_n && nmi_enable)) begin
          s_d.lp = CWLP_RUN;
        end
      end
      CWLP_STANDBY: begin
        // Unqualified wakes leave the device asleep
        if (|wake_qualified) begin
          s_d.lp = CWLP_RUN;
        end
      end
      CWLP_HALT: begin
        if (!nonmaskable_ext_input_n && nmi_enable) begin
          s_d.lp = CWLP_RUN;
        end
      end
      default: begin
        s_d.lp = CWLP_RUN;
      end
    endcase

    // Wake interrupt clears once consumed in run mode; a new overflow wins over the clear
    if (s_q.wd_int && s_q.lp == CWLP_RUN && !wd_set) begin
      s_d.wd_int = 1'b0;
    end

    // Clock gates by mode
    s_d.core_run = (s_d.lp == CWLP_RUN) || (s_d.lp == CWLP_IDLE);
    s_d.per_run = s_d.core_run;
    s_d.osc_run = (s_d.lp != CWLP_HALT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '0;
      s_q.ratio <= RATIO_RESET;
      s_q.clk_sel <= CLKSEL_BYPASS_DIV2;
      s_q.wd_rst_n <= 1'b1;
      s_q.lp <= CWLP_RUN;
      s_q.core_run <= 1'b1;
      s_q.osc_run <= 1'b1;
      s_q.per_run <= 1'b1;
    end else if (debug_reset) begin
      // Debugger reset: everything but the strap, ratio, reserved flag, clock select, PLL enable and held pins
      s_q <= '0;
      s_q.strap_taken <= s_q.strap_taken;
      s_q.pll_disabled <= s_q.pll_disabled;
      s_q.ratio <= s_q.ratio;
      s_q.reserved <= s_q.reserved;
      s_q.clk_sel <= s_q.clk_sel;
      s_q.pll_en <= s_q.pll_en;
      s_q.lp <= CWLP_RUN;
      s_q.pins <= s_q.pins;
      s_q.wd_rst_n <= 1'b1;
      s_q.core_run <= 1'b1;
      s_q.osc_run <= 1'b1;
      s_q.per_run <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pin_out = s_q.pins;
  assign pll_ratio_register = s_q.ratio;
  assign clk_path_sel = s_q.clk_sel;
  assign pll_enable = s_q.pll_en;
  assign ratio_reserved = s_q.reserved;
  assign core_clock_run = s_q.core_run;
  assign system_clock_run = s_q.core_run;
  assign oscillator_run = s_q.osc_run;
  assign peripheral_clock_run = s_q.per_run;
  assign wd_count = s_q.wd_cnt;
  assign watchdog_reset_out_n = s_q.wd_rst_n;
  assign watchdog_wake_interrupt = s_q.wd_int;
  assign cpu_wake_irq = s_q.cpu_irq;
  assign lp_state = s_q.lp;

endmodule

// file: logic/cwlp_wake_qual.sv
/*
  Wake qualifier: an active-low wake level must stay low for a set number of clocks.
  Assumes the wake level is synchronous to the system clock.
*/
`timescale 1ns/1ps
module cwlp_wake_qual
  import cwlp_pkg::*;
#(
  parameter int W = QUAL_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_sync_n,
  // Control
  input wire logic arm,
  input wire logic [W-1:0] qual_count,
  input wire logic wake_low,
  // Result
  output logic qualified
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic hit;
  } cwlp_qual_t;

  cwlp_qual_t s_q;
  cwlp_qual_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    // Low level must persist; a short glitch restarts the count
    if (!arm || wake_low) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= qual_count) begin
      s_d.hit = 1'b1;
      s_d.cnt = '0;
    end else begin
      s_d.cnt = W'(s_q.cnt + 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign qualified = s_q.hit;

endmodule

// file: tb/cwlp_ref_osc.sv
/*
  Reference oscillator model: oscillator ticks every second mclk and a lost-reference level.
  Assumes the block's oscillator_run output stops it and the bench may stall or lose it.
*/
`timescale 1ns/1ps
module cwlp_ref_osc (
  // Clock
  input wire logic mclk,
  // Control
  input wire logic osc_run,
  input wire logic stall,
  input wire logic lose,
  // Toward the block
  output logic tick,
  output logic lost
);
  logic div_q;
  initial begin
    div_q = 1'b0;
    tick = 1'b0;
    lost = 1'b0;
  end
  always @(posedge mclk) begin
    div_q <= ~div_q;
    tick <= osc_run && !stall && div_q;
    lost <= lose;
  end
endmodule

// file: tb/cwlp_top_monitor.sv
/*
  Concurrent checks on the ports of cwlp_top, attached by bind at the foot.
  Assumes one clock, mclk, and the active-low reset pin rst_n.
*/
`timescale 1ns/1ps
module cwlp_top_monitor
  import cwlp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs watched
  input wire logic debug_reset,
  input wire logic reference_lost,
  input wire logic pll_ratio_wr,
  input wire logic [RATIO_W-1:0] pll_ratio_wdata,
  input wire logic wd_enable,
  input wire logic wd_key_wr,
  input wire logic [7:0] wd_key_wdata,
  input wire logic oscillator_clock_tick,
  input wire logic idle_instr,
  input wire logic [1:0] lowpower_select,
  // Outputs watched
  input wire logic [7:0] pin_out,
  input wire logic [RATIO_W-1:0] pll_ratio_register,
  input wire logic [1:0] clk_path_sel,
  input wire logic core_clock_run,
  input wire logic system_clock_run,
  input wire logic oscillator_run,
  input wire logic [WD_CNT_W-1:0] wd_count,
  input wire logic watchdog_reset_out_n,
  input wire logic [3:0] lp_state
);
  logic [10:0] pulse_ticks_q;
  logic [10:0] pulse_ticks_d;
  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Oscillator ticks seen while the watchdog pulse is low
  always_comb begin
    pulse_ticks_d = pulse_ticks_q;
    if (watchdog_reset_out_n) pulse_ticks_d = 11'h000;
    else if (oscillator_clock_tick) pulse_ticks_d = pulse_ticks_q + 11'h001;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pulse_ticks_q <= 11'h000;
    else pulse_ticks_q <= pulse_ticks_d;
  end
  ////////////////////////////////////////
  sequence key_pair;
    wd_key_wr && wd_key_wdata == WD_KEY_FIRST ##1 wd_key_wr && wd_key_wdata == WD_KEY_SECOND;
  endsequence
  sequence in_standby;
    lp_state == CWLP_STANDBY [*2];
  endsequence
  sequence in_halt;
    lp_state == CWLP_HALT [*2];
  endsequence
  a_ratio_write: assert property (pll_ratio_wr |=> pll_ratio_register == $past(pll_ratio_wdata))
    else $error("ratio write not stored");
  a_debug_keeps_ratio: assert property (debug_reset && !pll_ratio_wr |=> $stable(pll_ratio_register))
    else $error("debug reset changed ratio");
  a_limp_needs_ratio: assert property (clk_path_sel == CLKSEL_LIMP |-> pll_ratio_register != RATIO_RESET)
    else $error("limp clock with zero ratio");
  a_limp_wd_hold: assert property (reference_lost && clk_path_sel == CLKSEL_LIMP && wd_enable && !wd_key_wr
    |=> $stable(wd_count))
    else $error("watchdog moved on limp clock");
  a_key_clears: assert property (key_pair |=> wd_count == 8'h00)
    else $error("key sequence did not clear counter");
  a_pulse_start: assert property ($fell(watchdog_reset_out_n) |-> $past(wd_count) == WD_CNT_MAX)
    else $error("reset pulse without overflow");
  a_pulse_width: assert property ($rose(watchdog_reset_out_n) |-> pulse_ticks_q == 11'h200)
    else $error("reset pulse width wrong");
  a_mode_encode: assert property (idle_instr && lp_state == CWLP_RUN |=> lp_state == ($past(lowpower_select[1])
    ? CWLP_HALT : ($past(lowpower_select[0]) ? CWLP_STANDBY : CWLP_IDLE)))
    else $error("wrong low-power mode entered");
  a_standby_clocks: assert property (in_standby |-> !core_clock_run && !system_clock_run && oscillator_run)
    else $error("standby clock states wrong");
  a_halt_stops: assert property (in_halt |-> !oscillator_run && $stable(wd_count))
    else $error("halt left oscillator or watchdog running");
  a_pins_hold: assert property (lp_state != CWLP_RUN |=> $stable(pin_out))
    else $error("pins moved in low-power mode");
endmodule

bind cwlp_top cwlp_top_monitor mon_u (.*);

// file: tb/testbench.sv
/*
  Self-checking bench for cwlp_top: task-driven scenarios with expected values.
  Assumes the package, the top module, the oscillator model and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
  import cwlp_pkg::*;
  logic mclk, rst_n, debug_reset, pll_disable_strap_n, reference_lost, pll_ratio_wr, wd_enable, wd_key_wr;
  logic wd_wake_mode, oscillator_clock_tick, idle_instr, nmi_enable, nonmaskable_ext_input_n;
  logic external_interrupt_one_n, timer_trip_inputs_n, compare_trip_inputs_n, serial_receive_wake_n;
  logic bus_receive_wake_n, debugger_wake, enabled_interrupt, pll_enable, ratio_reserved, core_clock_run;
  logic system_clock_run, oscillator_run, watchdog_reset_out_n, lose, stall;
  logic peripheral_clock_run, watchdog_wake_interrupt, cpu_wake_irq;
  logic [RATIO_W-1:0] pll_ratio_wdata, pll_ratio_register;
  logic [7:0] wd_key_wdata, pin_out_d, pin_out;
  logic [1:0] lowpower_select, clk_path_sel;
  logic [QUAL_W-1:0] lowpower_qual_count;
  logic [WAKE_W-1:0] lowpower_wake_select;
  logic [WD_CNT_W-1:0] wd_count, c;
  logic [3:0] lp_state;
  int fails, checks, n;
  cwlp_top dut_u (.*);
  cwlp_ref_osc ref_u (.mclk(mclk), .osc_run(oscillator_run), .stall(stall), .lose(lose),
    .tick(oscillator_clock_tick), .lost(reference_lost));
  ////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic wr_ratio(input logic [3:0] v);
    pll_ratio_wdata = v;
    pll_ratio_wr = 1'b1;
    cyc(1);
    pll_ratio_wr = 1'b0;
    cyc(1);
  endtask
  task automatic keys(input logic [7:0] a, input logic [7:0] b, input logic [7:0] d, input int k);
    logic [7:0] ks [3];
    ks = '{a, b, d};
    for (int i = 0; i < k; i++) begin
      wd_key_wdata = ks[i];
      wd_key_wr = 1'b1;
      cyc(1);
    end
    wd_key_wr = 1'b0;
  endtask
  task automatic enter(input logic [1:0] s);
    lowpower_select = s;
    idle_instr = 1'b1;
    cyc(1);
    idle_instr = 1'b0;
    cyc(1);
  endtask
  task automatic wait_lp(input logic [3:0] e, input int lim);
    int i;
    i = 0;
    while (lp_state !== e && i < lim) begin
      cyc(1);
      i++;
    end
    `CHK("lp_state", e, lp_state)
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    {rst_n, debug_reset, pll_ratio_wr, wd_enable, wd_key_wr, wd_wake_mode, idle_instr, nmi_enable} = 8'h00;
    {debugger_wake, enabled_interrupt, lose, stall} = 4'h0;
    {pll_disable_strap_n, nonmaskable_ext_input_n, external_interrupt_one_n, timer_trip_inputs_n} = 4'hf;
    {compare_trip_inputs_n, serial_receive_wake_n, bus_receive_wake_n} = 3'h7;
    {pll_ratio_wdata, wd_key_wdata, pin_out_d, lowpower_select} = 22'h000000;
    lowpower_qual_count = 6'h03;
    lowpower_wake_select = 8'h02;
    fails = 0;
    checks = 0;
    cyc(20);
    rst_n = 1'b1;
    cyc(4);
    `CHK("clk_path_sel", CLKSEL_BYPASS_DIV2, clk_path_sel)
    `CHK("ratio", RATIO_RESET, pll_ratio_register)
    wr_ratio(4'h3);
    `CHK("ratio", 4'h3, pll_ratio_register)
    `CHK("clk_path_sel", CLKSEL_PLL, clk_path_sel)
    `CHK("pll_enable", 1'b1, pll_enable)
    for (int v = 9; v < 16; v += 2) begin
      wr_ratio(4'(v));
      `CHK("ratio_reserved", (4'(v) > RATIO_MAX_LEGAL), ratio_reserved)
    end
    wr_ratio(4'h5);
    debug_reset = 1'b1;
    cyc(3);
    debug_reset = 1'b0;
    cyc(1);
    `CHK("ratio", 4'h5, pll_ratio_register)
    wd_enable = 1'b1;
    cyc(12);
    lose = 1'b1;
    cyc(3);
    `CHK("clk_path_sel", CLKSEL_LIMP, clk_path_sel)
    c = wd_count;
    cyc(20);
    `CHK("wd_count", c, wd_count)
    lose = 1'b0;
    stall = 1'b1;
    cyc(3);
    keys(WD_KEY_FIRST, WD_KEY_SECOND, 8'h00, 2);
    cyc(1);
    `CHK("wd_count", 8'h00, wd_count)
    stall = 1'b0;
    cyc(12);
    stall = 1'b1;
    cyc(2);
    c = wd_count;
    keys(WD_KEY_FIRST, 8'h12, WD_KEY_SECOND, 3);
    cyc(2);
    `CHK("wd_count", c, wd_count)
    stall = 1'b0;
    n = 0;
    while (watchdog_reset_out_n !== 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (watchdog_reset_out_n === 1'b0 && n < 2000) begin
      cyc(1);
      n++;
    end
    `CHK("reset_pulse_cycles", 1024, n)
    wd_enable = 1'b0;
    cyc(1);
    wd_wake_mode = 1'b1;
    wd_enable = 1'b1;
    enter(2'h0);
    `CHK("lp_state", CWLP_IDLE, lp_state)
    `CHK("core_clock_run", 1'b1, core_clock_run)
    wait_lp(CWLP_RUN, 600);
    `CHK("cpu_wake_irq", 1'b1, cpu_wake_irq)
    `CHK("watchdog_wake_interrupt", 1'b1, watchdog_wake_interrupt)
    wd_enable = 1'b0;
    enter(2'h0);
    enabled_interrupt = 1'b1;
    wait_lp(CWLP_RUN, 4);
    enabled_interrupt = 1'b0;
    pin_out_d = 8'ha5;
    cyc(2);
    enter(2'h1);
    `CHK("lp_state", CWLP_STANDBY, lp_state)
    `CHK("core_clock_run", 1'b0, core_clock_run)
    `CHK("oscillator_run", 1'b1, oscillator_run)
    `CHK("peripheral_clock_run", 1'b0, peripheral_clock_run)
    pin_out_d = 8'h5a;
    external_interrupt_one_n = 1'b0;
    cyc(3);
    external_interrupt_one_n = 1'b1;
    timer_trip_inputs_n = 1'b0;
    cyc(8);
    timer_trip_inputs_n = 1'b1;
    cyc(2);
    `CHK("lp_state", CWLP_STANDBY, lp_state)
    `CHK("pin_out", 8'ha5, pin_out)
    external_interrupt_one_n = 1'b0;
    wait_lp(CWLP_RUN, 10);
    external_interrupt_one_n = 1'b1;
    cyc(2);
    `CHK("pin_out", 8'h5a, pin_out)
    for (int s = 2; s < 4; s++) begin
      enter(2'(s));
      `CHK("lp_state", CWLP_HALT, lp_state)
      `CHK("oscillator_run", 1'b0, oscillator_run)
      nonmaskable_ext_input_n = 1'b0;
      cyc(4);
      `CHK("lp_state", CWLP_HALT, lp_state)
      nmi_enable = 1'b1;
      wait_lp(CWLP_RUN, 8);
      nonmaskable_ext_input_n = 1'b1;
      nmi_enable = 1'b0;
      cyc(2);
    end
    pll_disable_strap_n = 1'b0;
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(4);
    `CHK("clk_path_sel", CLKSEL_DIRECT, clk_path_sel)
    `CHK("ratio", RATIO_RESET, pll_ratio_register)
    end_sim();
  end
endmodule
